// *** rtl/ivm_vector_mapper.sv ***
// interrupt vector mapper: reset entry and 36 request vectors
// assumes peripheral requests are core-clock levels; external pin
// requests are asynchronous and synchronised here
//
// How it works
// - all reset causes go to vector one
// - external requests zero..seven at 0x0002..0x0010
// - async timer compare 0x0012, overflow 0x0014
// - first 16-bit timer 0x0016 to 0x001e
// - sync 8-bit timer compare 0x0020, overflow 0x0022
// - can event 0x0024, can timer overrun 0x0026
// - serial peripheral transfer done at 0x0028
// - first usart vectors 0x002a, 0x002c, 0x002e
// - second 16-bit timer 0x0036 to 0x003e
// - second usart vectors 0x0040, 0x0042, 0x0044
// - two-wire 0x0046, program store done 0x0048
// - select bit adds boot section start
// - programmed fuse resets to boot address
// - reset on fuse only, table on select only
// - fuse one unprogrammed, zero programmed
// - select bit in writable control register
module ivm_vector_mapper
    import ivm_pkg::*;
#(
    parameter ivm_addr_t BOOT_START = `IVM_BOOT_DEFAULT
) (
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    // reset causes
    input  wire logic              rst_pin,
    input  wire logic              rst_power_on,
    input  wire logic              rst_brown_out,
    input  wire logic              rst_watchdog,
    input  wire logic              rst_debug,
    // fuse
    input  wire logic              boot_reset_fuse,
    // control register write from the core
    input  ivm_ctrl_wr_t           ctrl_wr,
    // external pin requests zero..seven
    input  wire logic [7:0]        external_request,
    // timer requests
    input  wire logic              async_timer_compare,
    input  wire logic              async_timer_overflow,
    input  wire logic [4:0]        timer_a_events,
    input  wire logic              sync_timer_compare,
    input  wire logic              sync_timer_overflow,
    input  wire logic [4:0]        timer_b_events,
    // communication and misc requests
    input  wire logic              can_event_vector,
    input  wire logic              can_timer_overrun_vector,
    input  wire logic              spi_transfer_done,
    input  wire logic [2:0]        usart_a_events,
    input  wire logic [2:0]        usart_b_events,
    input  wire logic              comparator_event,
    input  wire logic              conversion_done,
    input  wire logic              data_memory_write_done,
    input  wire logic              two_wire_serial_unit,
    input  wire logic              program_store_done,
    // core handshake
    input  wire logic              vector_ack,
    // outputs to the program counter
    output ivm_vector_t            vector,
    output logic                   vector_table_select,
    output logic [7:0]             control_readback
);

////////////////////////////////////////////////////////////////////////
    // slot n sits two words past slot n-1
    function automatic ivm_addr_t slot_addr(input logic [5:0] n);
        ivm_addr_t a;
        a = ivm_addr_t'({n, 1'b0}) - ivm_addr_t'(`IVM_SLOT_WORDS);
        return a;
    endfunction

    function automatic ivm_addr_t place(input ivm_addr_t a,
                                        input logic      sel);
        return sel ? ivm_addr_t'(a + BOOT_START) : a;
    endfunction

////////////////////////////////////////////////////////////////////////
    // external pins: three stages, change counts once stages 2 and 3 agree
    logic [7:0] ext_s1;
    logic [7:0] ext_s2;
    logic [7:0] ext_s3;
    logic [7:0] ext_level;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ext_s1 <= 8'h00;
            ext_s2 <= 8'h00;
            ext_s3 <= 8'h00;
        end else begin
            ext_s1 <= external_request;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_ext
            always_ff @(posedge ref_clk) begin
                if (sys_rst) begin
                    ext_level[g] <= 1'b0;
                end else if (ext_s2[g] == ext_s3[g]) begin
                    ext_level[g] <= ext_s3[g];
                end
            end
        end
    endgenerate

////////////////////////////////////////////////////////////////////////
    // request bit i is vector i+2; order is the vector table order
    logic [`IVM_NUM_SRC-1:0] req;

    assign req = {
        program_store_done,
        two_wire_serial_unit,
        usart_b_events,
        timer_b_events,
        data_memory_write_done,
        conversion_done,
        comparator_event,
        usart_a_events,
        spi_transfer_done,
        can_timer_overrun_vector,
        can_event_vector,
        sync_timer_overflow,
        sync_timer_compare,
        timer_a_events,
        async_timer_overflow,
        async_timer_compare,
        ext_level
    };

    logic       any_req;
    logic [5:0] win_idx;

    ivm_prio_enc #(
        .N (`IVM_NUM_SRC)
    ) u_prio (
        .req   (req),
        .any   (any_req),
        .index (win_idx)
    );

    logic [7:0] ctrl_q;

    ivm_ctrl_reg u_ctrl (
        .ref_clk                    (ref_clk),
        .sys_rst                    (sys_rst),
        .wr                         (ctrl_wr),
        .processor_control_register (ctrl_q)
    );

    logic sel_now;
    assign sel_now = ctrl_q[`IVM_VSEL_BIT];

////////////////////////////////////////////////////////////////////////
    // fuse is captured by a clocked stage once reset is released
    logic fuse_q;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            fuse_q <= `IVM_FUSE_UNPROG;
        end else begin
            fuse_q <= fuse_q;
        end
    end

    logic fuse_taken;
    logic fuse_prog;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            fuse_taken <= 1'b0;
            fuse_prog  <= 1'b0;
        end else if (!fuse_taken) begin
            fuse_taken <= 1'b1;
            fuse_prog  <= (boot_reset_fuse == `IVM_FUSE_PROG);
        end
    end

    logic any_reset;
    assign any_reset = rst_pin | rst_power_on | rst_brown_out
                     | rst_watchdog | rst_debug;

    // reset entry ignores the select bit entirely
    ivm_addr_t reset_addr;
    assign reset_addr = fuse_prog ? BOOT_START
                                  : `IVM_RESET_VEC;

////////////////////////////////////////////////////////////////////////
    // state: reset entry is presented first, then requests one at a time
    ivm_state_t state;
    ivm_state_t next_state;

    always_comb begin
        next_state = state;
        case (state)
            IVM_ST_RESET: if (fuse_taken) next_state = IVM_ST_IDLE;
            IVM_ST_IDLE:  if (vector_ack && vector.valid)
                              next_state = IVM_ST_TAKEN;
            IVM_ST_TAKEN: next_state = IVM_ST_IDLE;
            default:      next_state = IVM_ST_RESET;
        endcase
        if (any_reset) next_state = IVM_ST_RESET;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state <= IVM_ST_RESET;
        end else begin
            state <= next_state;
        end
    end

    // a reset entry stays pending until the core acknowledges it
    logic reset_pending;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            reset_pending <= 1'b1;
        end else if (any_reset) begin
            reset_pending <= 1'b1;
        end else if (vector_ack && vector.valid && vector.is_reset) begin
            reset_pending <= 1'b0;
        end
    end

////////////////////////////////////////////////////////////////////////
    // registered vector output; cleared for one cycle after an ack
    // so the core never sees a stale slot under its ack
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            vector <= '0;
        end else if (state == IVM_ST_RESET || any_reset) begin
            vector <= '0;
        end else if (state == IVM_ST_TAKEN) begin
            vector <= '0;
        end else if (reset_pending) begin
            vector.valid    <= 1'b1;
            vector.is_reset <= 1'b1;
            vector.number   <= 6'h01;
            vector.address  <= reset_addr;
        end else if (any_req) begin
            vector.valid    <= 1'b1;
            vector.is_reset <= 1'b0;
            vector.number   <= 6'(win_idx + 6'h02);
            vector.address  <= place(slot_addr(6'(win_idx + 6'h02)),
                                     sel_now);
        end else begin
            vector <= '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            vector_table_select <= 1'b0;
            control_readback    <= `IVM_CTRL_RESET;
        end else begin
            vector_table_select <= sel_now;
            control_readback    <= ctrl_q;
        end
    end

    logic unused_fuse;
    assign unused_fuse = fuse_q;

endmodule // ivm_vector_mapper

// *** rtl/ivm_map.svh ***
// vector mapper constants: addresses, field positions, reset values
// assumes inclusion from rtl files only; definitions only
`ifndef IVM_MAP_SVH
`define IVM_MAP_SVH
`define IVM_PC_W          16
`define IVM_NUM_SRC       36
`define IVM_NUM_VEC       37
`define IVM_RESET_VEC     16'h0000
`define IVM_TABLE_BASE    16'h0002
`define IVM_LAST_VEC      16'h0048
`define IVM_SLOT_WORDS    2
`define IVM_BOOT_DEFAULT  16'hf000
`define IVM_VSEL_BIT      1
`define IVM_CTRL_RESET    8'h00
`define IVM_FUSE_UNPROG   1'b1
`define IVM_FUSE_PROG     1'b0
`endif

// *** rtl/ivm_pkg.sv ***
// vector mapper types
// assumes ivm_map.svh is on the include path
package ivm_pkg;
    `include "ivm_map.svh"
    typedef logic [`IVM_PC_W-1:0] ivm_addr_t;
    typedef struct packed {
        logic      valid;
        logic      is_reset;
        logic [5:0] number;
        ivm_addr_t address;
    } ivm_vector_t;
    typedef struct packed {
        logic       write;
        logic [7:0] data;
    } ivm_ctrl_wr_t;
    typedef enum logic [1:0] {
        IVM_ST_RESET = 2'b00,
        IVM_ST_IDLE  = 2'b01,
        IVM_ST_TAKEN = 2'b11
    } ivm_state_t;
endpackage

// *** rtl/ivm_prio_enc.sv ***
// fixed priority encoder: lowest request index wins
// assumes requests already synchronous to the core clock
module ivm_prio_enc #(
    parameter int N = 36
) (
    // requests
    input  wire logic [N-1:0] req,
    // result
    output logic              any,
    output logic [5:0]        index
);
    always_comb begin
        any   = 1'b0;
        index = 6'h00;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                any   = 1'b1;
                index = i[5:0];
            end
        end
    end
endmodule // ivm_prio_enc

// *** rtl/ivm_ctrl_reg.sv ***
// processor control register holding the vector-table select bit
// assumes the core writes it with a one-cycle write strobe
module ivm_ctrl_reg
    import ivm_pkg::*;
(
    // clock and reset
    input  wire logic   ref_clk,
    input  wire logic   sys_rst,
    // core write port
    input  ivm_ctrl_wr_t wr,
    // contents
    output logic [7:0]  processor_control_register
);
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            processor_control_register <= `IVM_CTRL_RESET;
        end else if (wr.write) begin
            processor_control_register <= wr.data;
        end
    end
endmodule // ivm_ctrl_reg

// *** sim/ivm_checker.sv ***
// checker: vector mapper port relations
// assumes one clock and a synchronous active-high reset
module ivm_checker
    import ivm_pkg::*;
#(
    parameter ivm_addr_t BOOT_START = 16'hf000
) (
    // clock, reset and reset causes
    input wire logic   ref_clk,
    input wire logic   sys_rst,
    input wire logic   rst_pin,
    input wire logic   rst_power_on,
    input wire logic   rst_brown_out,
    input wire logic   rst_watchdog,
    input wire logic   rst_debug,
    // setup
    input wire logic   boot_reset_fuse,
    input ivm_ctrl_wr_t ctrl_wr,
    // outputs watched
    input ivm_vector_t  vector,
    input wire logic   vector_table_select
);
    logic      any_rst;
    logic      vr;
    logic      vi;
    logic      last_sel;
    ivm_addr_t slot;
    assign any_rst = rst_pin | rst_power_on | rst_brown_out | rst_watchdog
                   | rst_debug;
    assign vr = vector.valid && vector.is_reset;
    assign vi = vector.valid && !vector.is_reset;
    assign slot = 16'({vector.number - 6'h01, 1'b0});
    always_ff @(posedge ref_clk) begin
        if (sys_rst) last_sel <= 1'b0;
        else if (ctrl_wr.write) last_sel <= ctrl_wr.data[1];
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    AST_RESET_ADDR: assert property (vr |-> vector.address ==
        (boot_reset_fuse ? 16'h0000 : BOOT_START)) else $error("reset addr");
    AST_RESET_NUM: assert property (vr |-> vector.number == 6'h01)
        else $error("reset vector number");
    AST_CAUSE: assert property (any_rst |-> ##[1:4] vr)
        else $error("reset cause ignored");
    AST_SLOT: assert property (vi && !vector_table_select |->
        vector.address == slot) else $error("slot address");
    AST_BOOT: assert property (vi && vector_table_select |->
        vector.address == slot + BOOT_START) else $error("boot offset");
    AST_RANGE: assert property (vi |-> vector.number inside
        {[6'h02:6'h25]}) else $error("vector number range");
    AST_SEL: assert property ($past(ctrl_wr.write) |-> ##[0:1]
        vector_table_select == last_sel) else $error("select bit");
    AST_RST_CLR: assert property (disable iff (1'b0) sys_rst |=>
        !vector.valid && !vector_table_select) else $error("reset clear");
endmodule // ivm_checker

bind ivm_vector_mapper ivm_checker #(.BOOT_START(BOOT_START)) i_ivm_checker (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .rst_pin(rst_pin),
    .rst_power_on(rst_power_on), .rst_brown_out(rst_brown_out),
    .rst_watchdog(rst_watchdog), .rst_debug(rst_debug),
    .boot_reset_fuse(boot_reset_fuse), .ctrl_wr(ctrl_wr),
    .vector(vector), .vector_table_select(vector_table_select));

// *** sim/ivm_core_model.sv ***
// core model: takes each offered vector with an ack pulse
// assumes vector clears for a cycle after each ack
module ivm_core_model
    import ivm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic slow,
    input ivm_vector_t vector,
    output logic     vector_ack
);
    logic [1:0] wait_cnt;
    // slow mode lets the vector stand a few cycles before it is taken
    always_ff @(posedge ref_clk) begin
        if (sys_rst || vector_ack) begin
            vector_ack <= 1'b0;
            wait_cnt   <= 2'h0;
        end else if (vector.valid) begin
            if (wait_cnt >= (slow ? 2'h3 : 2'h0)) vector_ack <= 1'b1;
            else wait_cnt <= wait_cnt + 2'h1;
        end
    end
endmodule // ivm_core_model

// *** sim/ivm_vector_mapper_tb_top.sv ***
// bench: vector table, select offset, priority, reset causes, fuse
// assumes the core model acks every vector it sees
module ivm_vector_mapper_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ivm_pkg::*;
    typedef struct {logic [35:0] r; logic [5:0] n; ivm_addr_t a;} ivm_row_t;
    localparam ivm_addr_t BOOT = 16'h1c00;
    logic ref_clk = 0, sys_rst = 1, fuse = 1, slow = 0, ack, sel;
    logic [4:0] rc = '0;
    logic [35:0] req = '0;
    logic [7:0] rb;
    ivm_ctrl_wr_t wr = '0;
    ivm_vector_t vec;
    int mismatches = 0, check_count = 0, cycles = 0;
    ivm_row_t rows[36];
    always #10 ref_clk = ~ref_clk;
    ivm_vector_mapper #(.BOOT_START(BOOT)) i_ivm_vector_mapper (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .rst_pin(rc[0]),
        .rst_power_on(rc[1]), .rst_brown_out(rc[2]), .rst_watchdog(rc[3]),
        .rst_debug(rc[4]), .boot_reset_fuse(fuse), .ctrl_wr(wr),
        .external_request(req[7:0]), .async_timer_compare(req[8]),
        .async_timer_overflow(req[9]), .timer_a_events(req[14:10]),
        .sync_timer_compare(req[15]), .sync_timer_overflow(req[16]),
        .timer_b_events(req[30:26]), .can_event_vector(req[17]),
        .can_timer_overrun_vector(req[18]), .spi_transfer_done(req[19]),
        .usart_a_events(req[22:20]), .usart_b_events(req[33:31]),
        .comparator_event(req[23]), .conversion_done(req[24]),
        .data_memory_write_done(req[25]), .two_wire_serial_unit(req[34]),
        .program_store_done(req[35]), .vector_ack(ack), .vector(vec),
        .vector_table_select(sel), .control_readback(rb));
    ivm_core_model i_ivm_core_model (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .slow(slow), .vector(vec), .vector_ack(ack));
    ////////////////////////////////////////////////////////////////////////
    task check(input string nm, input logic [15:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // external pins re-raise from their synchroniser, so drain afterwards
    task take(input logic [5:0] n, input ivm_addr_t a);
        int i;
        i = 0;
        while (vec.valid !== 1'b1 && i < 30) begin
            @(negedge ref_clk);
            i++;
        end
        check("number", {10'h0, vec.number}, {10'h0, n});
        check("address", vec.address, a);
        i = 0;
        while (ack !== 1'b1 && i < 10) begin
            @(negedge ref_clk);
            i++;
        end
        @(posedge ref_clk) req <= '0;
        repeat (10) @(posedge ref_clk);
    endtask
    task test_done();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            test_done();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        for (int i = 0; i < 36; i++) rows[i] = '{36'h1 << i, 6'(i + 2),
            16'(2 * (i + 1))};
        repeat (8) @(negedge ref_clk);
        check("reset", {14'h0, vec.valid, sel}, 16'h0);
        @(posedge ref_clk) sys_rst <= 0;
        take(6'h01, 16'h0000);
        for (int s = 0; s < 2; s++) begin
            @(posedge ref_clk) wr <= '{1'b1, 8'(s * 2)};
            @(posedge ref_clk) wr <= '0;
            repeat (3) @(negedge ref_clk);
            check("readback", {8'h0, rb}, 16'(s * 2));
            check("select", {15'h0, sel}, 16'(s));
            foreach (rows[i]) begin
                @(posedge ref_clk) req <= rows[i].r;
                take(rows[i].n, rows[i].a + (s ? BOOT : 16'h0));
            end
        end
        // lowest number wins when two requests arrive together
        @(posedge ref_clk) req <= (36'h1 << 30) | (36'h1 << 12);
        take(6'd14, BOOT + 16'h001a);
        for (int c = 0; c < 5; c++) begin
            @(posedge ref_clk) rc <= 5'h1 << c;
            @(posedge ref_clk) rc <= '0;
            take(6'h01, 16'h0000);
        end
        @(posedge ref_clk) sys_rst <= 1;
        fuse <= 0;
        slow <= 1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 0;
        take(6'h01, BOOT);
        @(posedge ref_clk) req <= rows[35].r;
        take(rows[35].n, rows[35].a);
        test_done();
    end
endmodule // ivm_vector_mapper_tb_top
